// file: hdl/nfh_host.sv
// NAND host controller: register slave, command sequencer, pin engine
// Operation
// - Command byte latched on write rise, cmd latch
// - Address byte latched on write rise, addr latch
// - Column: two cycles, low first, top zero
// - Row: three cycles, low first, top zero
// - Cycle type from latch strobes
// - Strobes high while array read busy
// - Opcodes 00/30, 60/D0, 90
// - Output column change: 05, column, E0
// - Program 80, address, data, 10; 85
// - Opcode 70 then reads return status
// - At most 2112 data bytes per page
// - After 85, two cycles give new column
//
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module nfh_host (
  input  wire logic        clk,              // 125 MHz clock
  input  wire logic        rst_n,            // Async reset, low
  input  wire logic [7:0]  s_axi_awaddr,     // Write address
  input  wire logic        s_axi_awvalid,    // Write address valid
  output var logic         s_axi_awready,    // Write address ready
  input  wire logic [31:0] s_axi_wdata,      // Write data
  input  wire logic [3:0]  s_axi_wstrb,      // Byte enables
  input  wire logic        s_axi_wvalid,     // Write data valid
  output var logic         s_axi_wready,     // Write data ready
  output var logic [1:0]   s_axi_bresp,      // Write response
  output var logic         s_axi_bvalid,     // Write response valid
  input  wire logic        s_axi_bready,     // Write response ready
  input  wire logic [7:0]  s_axi_araddr,     // Read address
  input  wire logic        s_axi_arvalid,    // Read address valid
  output var logic         s_axi_arready,    // Read address ready
  output var logic [31:0]  s_axi_rdata,      // Read data
  output var logic [1:0]   s_axi_rresp,      // Read response
  output var logic         s_axi_rvalid,     // Read data valid
  input  wire logic        s_axi_rready,     // Read data ready
  output var logic         cmd_latch,        // Command latch strobe
  output var logic         addr_latch,       // Address latch strobe
  output var logic         select_n,         // Device select, low
  output var logic         write_strobe_n,   // Write strobe, low
  output var logic         read_strobe_low,  // Read strobe, low
  output var logic         guard_n,          // Program guard, low
  output var logic [7:0]   shared_byte_bus_o,  // Bus drive value
  output var logic         shared_byte_bus_oe, // Bus drive enable
  input  wire logic [7:0]  shared_byte_bus_i,  // Bus level
  input  wire logic        ready_busy_line   // High when ready
);
  import nfh_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_STEP = 3'b001,
    S_WAIT = 3'b011,
    S_WB   = 3'b010,
    S_RDY  = 3'b110
  } nfh_st_t;

  nfh_cyc_if cyc ();

  // Bus slave state
  logic [7:0]  aw_addr_r;
  logic [31:0] wd_r;
  logic [3:0]  ws_r;
  logic        aw_full_r;
  logic        w_full_r;
  // Registers of the controller
  logic [COL_W-1:0] col_r;
  logic [ROW_W-1:0] row_r;
  logic [1:0]  cfg_r;
  logic        refused_r;
  logic [11:0] din_cnt_r;
  logic [7:0]  rbyte_r;
  // Sequencer
  nfh_st_t     st_r;
  logic [3:0]  op_r;
  logic [2:0]  k_r;
  logic [7:0]  wb_cnt_r;
  logic        start_r;
  nfh_kind_t   kind_r;
  logic [7:0]  wbyte_r;
  // Write decode
  wire wr_en   = aw_full_r && w_full_r && !s_axi_bvalid;
  wire wr_ctrl = wr_en && (aw_addr_r == REG_CTRL);
  wire wr_col  = wr_en && (aw_addr_r == REG_COL);
  wire wr_row  = wr_en && (aw_addr_r == REG_ROW);
  wire wr_cfg  = wr_en && (aw_addr_r == REG_CFG);
  wire wr_hit  = (aw_addr_r == REG_CTRL) || (aw_addr_r == REG_COL) ||
                 (aw_addr_r == REG_ROW) || (aw_addr_r == REG_CFG) ||
                 (aw_addr_r == REG_STATUS);
  wire [3:0] go_op   = wd_r[CTRL_OP_LSB +: 4];
  wire [7:0] go_byte = wd_r[CTRL_BYTE_LSB +: 8];
  wire go        = wr_ctrl && ws_r[0];
  wire idle      = (st_r == S_IDLE);
  wire guard_op  = (go_op == OP_PROG) || (go_op == OP_CONFIRM) ||
                   (go_op == OP_ERASE) || (go_op == OP_WRBYTE) ||
                   (go_op == OP_INCOL);
  wire page_full = (go_op == OP_WRBYTE) && (din_cnt_r == PAGE_BYTES);
  wire blocked   = (guard_op && !cfg_r[CFG_GUARD_BIT]) ||
                   page_full ||
                   (go_op > OP_RDBYTE);
  wire accept    = go && idle && !blocked;
  wire refuse    = go && !accept;

  // Read decode
  wire ar_hs   = s_axi_arvalid && s_axi_arready;
  wire rd_stat = ar_hs && (s_axi_araddr == REG_STATUS);
  wire [31:0] status_w = {4'h0, din_cnt_r, rbyte_r,
                          2'b00, rbyte_r[ST_UNPROT_BIT],
                          rbyte_r[ST_READY_BIT],
                          rbyte_r[ST_FAIL_BIT],
                          refused_r, ready_busy_line, !idle};
  wire rd_hit = (s_axi_araddr == REG_CTRL) ||
                (s_axi_araddr == REG_COL) ||
                (s_axi_araddr == REG_ROW) ||
                (s_axi_araddr == REG_STATUS) ||
                (s_axi_araddr == REG_CFG);
  wire [31:0] rd_mux =
    (s_axi_araddr == REG_CTRL)   ? {20'h0, op_r, 8'h00} :
    (s_axi_araddr == REG_COL)    ? {20'h0, col_r} :
    (s_axi_araddr == REG_ROW)    ? {13'h0, row_r} :
    (s_axi_araddr == REG_STATUS) ? status_w :
    (s_axi_araddr == REG_CFG)    ? {30'h0, cfg_r} : 32'h0;

  // Address bytes: column low first, upper bits zero
  logic [7:0] abyte [5];
  assign abyte[0] = col_r[7:0];
  assign abyte[1] = {4'h0, col_r[11:8]};
  assign abyte[2] = row_r[7:0];
  assign abyte[3] = row_r[15:8];
  assign abyte[4] = {5'h00, row_r[18:16]};

  // Step table per operation
  nfh_kind_t  sk;
  logic [7:0] sb;
  logic [2:0] last_k;
  logic       needs_wait;
  always_comb begin
    sk = K_CMD;
    sb = 8'h00;
    last_k = 3'd0;
    needs_wait = 1'b0;
    case (op_r)
      OP_READ: begin
        last_k = 3'd6;
        needs_wait = 1'b1;
        sk = (k_r == 3'd0 || k_r == 3'd6) ? K_CMD : K_ADDR;
        sb = (k_r == 3'd0) ? CMD_READ1 :
             (k_r == 3'd6) ? CMD_READ2 : abyte[k_r - 3'd1];
      end
      OP_OUTCOL: begin
        last_k = 3'd3;
        sk = (k_r == 3'd0 || k_r == 3'd3) ? K_CMD : K_ADDR;
        sb = (k_r == 3'd0) ? CMD_OCOL1 :
             (k_r == 3'd3) ? CMD_OCOL2 : abyte[k_r - 3'd1];
      end
      OP_PROG: begin
        last_k = 3'd5;
        sk = (k_r == 3'd0) ? K_CMD : K_ADDR;
        sb = (k_r == 3'd0) ? CMD_PROG1 : abyte[k_r - 3'd1];
      end
      OP_INCOL: begin
        last_k = 3'd2;
        sk = (k_r == 3'd0) ? K_CMD : K_ADDR;
        sb = (k_r == 3'd0) ? CMD_ICOL : abyte[k_r - 3'd1];
      end
      OP_CONFIRM: begin
        needs_wait = 1'b1;
        sb = CMD_PROG2;
      end
      OP_ERASE: begin
        last_k = 3'd4;
        needs_wait = 1'b1;
        sk = (k_r == 3'd0 || k_r == 3'd4) ? K_CMD : K_ADDR;
        sb = (k_r == 3'd0) ? CMD_ERASE1 :
             (k_r == 3'd4) ? CMD_ERASE2 : abyte[k_r + 3'd1];
      end
      OP_IDENT: begin
        last_k = 3'd1;
        sk = (k_r == 3'd0) ? K_CMD : K_ADDR;
        sb = (k_r == 3'd0) ? CMD_IDENT : IDENT_ADDR;
      end
      OP_STATUS: sb = CMD_STATUS;
      OP_RESET: begin
        needs_wait = 1'b1;
        sb = CMD_RESET;
      end
      OP_WRBYTE: begin
        sk = K_DIN;
        sb = wbyte_r;
      end
      OP_RDBYTE: sk = K_DOUT;
      default: sk = K_CMD;
    endcase
  end

  // Write address and data channels, either order
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= 8'h00;
      wd_r <= 32'h0;
      ws_r <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_r <= s_axi_awaddr;
        aw_full_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wd_r <= s_axi_wdata;
        ws_r <= s_axi_wstrb;
        w_full_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_en) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read channel
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Address and configuration registers, byte lanes honoured
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      col_r <= '0;
      row_r <= '0;
      cfg_r <= CFG_RESET;
    end else begin
      if (wr_col && ws_r[0]) col_r[7:0] <= wd_r[7:0];
      if (wr_col && ws_r[1]) col_r[11:8] <= wd_r[11:8];
      if (wr_row && ws_r[0]) row_r[7:0] <= wd_r[7:0];
      if (wr_row && ws_r[1]) row_r[15:8] <= wd_r[15:8];
      if (wr_row && ws_r[2]) row_r[18:16] <= wd_r[18:16];
      if (wr_cfg && ws_r[0]) cfg_r <= wd_r[1:0];
    end
  end

  // Refused flag: set wins over clear on status read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refused_r <= 1'b0;
    end else if (refuse) begin
      refused_r <= 1'b1;
    end else if (rd_stat) begin
      refused_r <= 1'b0;
    end
  end

  // Data bytes loaded into the current page
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      din_cnt_r <= 12'h000;
    end else if (accept && go_op == OP_PROG) begin
      din_cnt_r <= 12'h000;
    end else if (accept && go_op == OP_WRBYTE) begin
      din_cnt_r <= din_cnt_r + 12'h001;
    end
  end

  // Operation sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= S_IDLE;
      op_r <= OP_STATUS;
      k_r <= 3'd0;
      wb_cnt_r <= 8'h00;
      start_r <= 1'b0;
      kind_r <= K_CMD;
      wbyte_r <= 8'h00;
      rbyte_r <= 8'h00;
    end else begin
      start_r <= 1'b0;
      case (st_r)
        S_IDLE: begin
          if (accept) begin
            op_r <= go_op;
            wbyte_r <= go_byte;
            k_r <= 3'd0;
            st_r <= S_STEP;
          end
        end
        S_STEP: begin
          start_r <= 1'b1;
          kind_r <= sk;
          wbyte_r <= sb;
          st_r <= S_WAIT;
        end
        S_WAIT: begin
          if (cyc.done) begin
            if (kind_r == K_DOUT) rbyte_r <= cyc.rbyte;
            if (k_r != last_k) begin
              k_r <= k_r + 3'd1;
              st_r <= S_STEP;
            end else if (needs_wait) begin
              wb_cnt_r <= WB_CYC;
              st_r <= S_WB;
            end else begin
              st_r <= S_IDLE;
            end
          end
        end
        S_WB: begin
          // Busy may take this long to appear
          if (wb_cnt_r == 8'h01) st_r <= S_RDY;
          else wb_cnt_r <= wb_cnt_r - 8'h01;
        end
        S_RDY: begin
          if (ready_busy_line) st_r <= S_IDLE;
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // Select held low except standby requested while idle and ready
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      select_n <= 1'b0;
      guard_n <= 1'b0;
    end else begin
      select_n <= cfg_r[CFG_STANDBY_BIT] && idle && !accept &&
                  ready_busy_line;
      guard_n <= cfg_r[CFG_GUARD_BIT];
    end
  end

  assign cyc.start = start_r;
  assign cyc.kind  = kind_r;
  assign cyc.wbyte = wbyte_r;

  // Pin cycle engine
  nfh_cycle u_cycle (
    .clk               (clk),
    .rst_n             (rst_n),
    .cyc               (cyc.eng),
    .cmd_latch_r       (cmd_latch),
    .addr_latch_r      (addr_latch),
    .write_strobe_n_r  (write_strobe_n),
    .read_strobe_low_r (read_strobe_low),
    .bus_o_r           (shared_byte_bus_o),
    .bus_oe_r          (shared_byte_bus_oe),
    .bus_i             (shared_byte_bus_i)
  );
endmodule // nfh_host
`default_nettype wire

// file: hdl/nfh_pkg.sv
// Constants and types for the NAND host port controller
package nfh_pkg;
  // Clock rate and pin timing in ns
  localparam int CLK_MHZ  = 125;
  localparam int T_WP_NS  = 25;   // Write strobe low, least
  localparam int T_RP_NS  = 35;   // Read strobe low, covers access delay
  localparam int T_HI_NS  = 30;   // Strobe high gap, least
  localparam int T_WB_NS  = 200;  // Strobe high to busy, longest
  // Cycle counts, rounded up
  localparam logic [7:0] WP_CYC = 8'((T_WP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] RP_CYC = 8'((T_RP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] HI_CYC = 8'((T_HI_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] WB_CYC = 8'((T_WB_NS * CLK_MHZ + 999) / 1000);

  // Page geometry
  localparam logic [11:0] PAGE_BYTES = 12'd2112;
  localparam int COL_W = 12;
  localparam int ROW_W = 19;

  // Device opcodes
  localparam logic [7:0] CMD_READ1  = 8'h00;
  localparam logic [7:0] CMD_READ2  = 8'h30;
  localparam logic [7:0] CMD_OCOL1  = 8'h05;
  localparam logic [7:0] CMD_OCOL2  = 8'he0;
  localparam logic [7:0] CMD_PROG1  = 8'h80;
  localparam logic [7:0] CMD_PROG2  = 8'h10;
  localparam logic [7:0] CMD_ICOL   = 8'h85;
  localparam logic [7:0] CMD_ERASE1 = 8'h60;
  localparam logic [7:0] CMD_ERASE2 = 8'hd0;
  localparam logic [7:0] CMD_IDENT  = 8'h90;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_RESET  = 8'hff;
  localparam logic [7:0] IDENT_ADDR = 8'h00;

  // Status byte fields
  localparam int ST_FAIL_BIT  = 0;
  localparam int ST_READY_BIT = 6;
  localparam int ST_UNPROT_BIT = 7;

  // Bus cycle kinds
  typedef enum logic [1:0] {
    K_CMD  = 2'b00,
    K_ADDR = 2'b01,
    K_DIN  = 2'b11,
    K_DOUT = 2'b10
  } nfh_kind_t;

  // Operations ordered through the control register
  localparam logic [3:0] OP_READ    = 4'h0;
  localparam logic [3:0] OP_OUTCOL  = 4'h1;
  localparam logic [3:0] OP_PROG    = 4'h2;
  localparam logic [3:0] OP_INCOL   = 4'h3;
  localparam logic [3:0] OP_CONFIRM = 4'h4;
  localparam logic [3:0] OP_ERASE   = 4'h5;
  localparam logic [3:0] OP_IDENT   = 4'h6;
  localparam logic [3:0] OP_STATUS  = 4'h7;
  localparam logic [3:0] OP_RESET   = 4'h8;
  localparam logic [3:0] OP_WRBYTE  = 4'h9;
  localparam logic [3:0] OP_RDBYTE  = 4'ha;

  // Register offsets and fields
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_COL    = 8'h04;
  localparam logic [7:0] REG_ROW    = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_CFG    = 8'h10;
  localparam int CTRL_OP_LSB   = 0;
  localparam int CTRL_BYTE_LSB = 8;
  localparam int CFG_GUARD_BIT   = 0;
  localparam int CFG_STANDBY_BIT = 1;
  localparam logic [1:0] CFG_RESET  = 2'h0;
  localparam logic [1:0] RESP_OKAY  = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// file: hdl/nfh_cyc_if.sv
// Request and answer carrier between sequencer and pin cycle engine
`timescale 1ns/1ns
`default_nettype none
interface nfh_cyc_if;
  import nfh_pkg::*;
  logic      start;  // One-cycle request
  nfh_kind_t kind;   // Cycle kind
  logic [7:0] wbyte; // Byte to drive
  logic      done;   // One-cycle completion
  logic [7:0] rbyte; // Byte sampled on output cycles
  modport seq (output start, kind, wbyte, input done, rbyte);
  modport eng (input start, kind, wbyte, output done, rbyte);
endinterface
`default_nettype wire

// file: hdl/nfh_cycle.sv
// One strobed bus cycle on the NAND pins
`timescale 1ns/1ns
`default_nettype none
module nfh_cycle (
  input  wire logic  clk,            // 125 MHz clock
  input  wire logic  rst_n,          // Async reset
  nfh_cyc_if.eng     cyc,            // Cycle requests
  output var logic   cmd_latch_r,    // Command latch strobe
  output var logic   addr_latch_r,   // Address latch strobe
  output var logic   write_strobe_n_r, // Write strobe
  output var logic   read_strobe_low_r, // Read strobe, low active
  output var logic [7:0] bus_o_r,    // Bus drive value
  output var logic   bus_oe_r,       // Bus drive enable
  input  wire logic [7:0] bus_i      // Bus sampled value
);
  import nfh_pkg::*;

  typedef enum logic [1:0] {
    C_IDLE = 2'b00,
    C_LOW  = 2'b01,
    C_HIGH = 2'b11
  } nfh_cst_t;

  nfh_cst_t   st_r;
  logic [7:0] cnt_r;
  logic [7:0] rbyte_r;
  logic       done_r;
  wire        is_rd = (cyc.kind == K_DOUT);
  wire        cnt_zero = (cnt_r == 8'h01);

  assign cyc.done  = done_r;
  assign cyc.rbyte = rbyte_r;

  // Strobe sequencing: latches set, strobe low, strobe high, release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= C_IDLE;
      cnt_r <= 8'h00;
      rbyte_r <= 8'h00;
      done_r <= 1'b0;
      cmd_latch_r <= 1'b0;
      addr_latch_r <= 1'b0;
      write_strobe_n_r <= 1'b1;
      read_strobe_low_r <= 1'b1;
      bus_o_r <= 8'h00;
      bus_oe_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (st_r)
        C_IDLE: begin
          if (cyc.start) begin
            cmd_latch_r <= (cyc.kind == K_CMD);
            addr_latch_r <= (cyc.kind == K_ADDR);
            bus_o_r <= cyc.wbyte;
            bus_oe_r <= !is_rd;
            write_strobe_n_r <= is_rd;
            read_strobe_low_r <= !is_rd;
            cnt_r <= is_rd ? RP_CYC : WP_CYC;
            st_r <= C_LOW;
          end
        end
        C_LOW: begin
          if (cnt_zero) begin
            // Rising write edge latches command, address or data
            write_strobe_n_r <= 1'b1;
            read_strobe_low_r <= 1'b1;
            if (is_rd) begin
              rbyte_r <= bus_i;
            end
            cnt_r <= HI_CYC;
            st_r <= C_HIGH;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        C_HIGH: begin
          if (cnt_zero) begin
            cmd_latch_r <= 1'b0;
            addr_latch_r <= 1'b0;
            bus_oe_r <= 1'b0;
            done_r <= 1'b1;
            st_r <= C_IDLE;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        default: st_r <= C_IDLE;
      endcase
    end
  end
endmodule // nfh_cycle
`default_nettype wire

// file: test/nfh_checker.sv
// Pin timing checks for the NAND host controller
`timescale 1ns/1ns
`default_nettype none
module nfh_checker (
  input wire logic       clk,                // Clock
  input wire logic       rst_n,              // Reset
  input wire logic       cmd_latch,          // Cmd latch
  input wire logic       addr_latch,         // Addr latch
  input wire logic       write_strobe_n,     // Write
  input wire logic       read_strobe_low,    // Read
  input wire logic [7:0] shared_byte_bus_o,  // Drive value
  input wire logic       shared_byte_bus_oe, // Drive enable
  input wire logic       ready_busy_line     // Ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Strobe low phases
  sequence s_wlow; !write_strobe_n [*4]; endsequence
  sequence s_rlow; !read_strobe_low [*5]; endsequence
  // Cycle kind and strobe shapes
  AST_ONE_LATCH: assert property (!(cmd_latch && addr_latch))
    else $error("both latches high");
  AST_WR_PULSE: assert property (
    $fell(write_strobe_n) |-> s_wlow ##1 write_strobe_n)
    else $error("write pulse length");
  AST_WR_LATCH: assert property ($rose(write_strobe_n) |->
    $stable(cmd_latch) && $stable(addr_latch) && $stable(shared_byte_bus_o))
    else $error("latch or data moved at write rise");
  AST_WR_DRIVE: assert property (
    !write_strobe_n |-> shared_byte_bus_oe)
    else $error("bus not driven in write");
  AST_WR_DATA: assert property (
    !write_strobe_n && !$past(write_strobe_n) |-> $stable(shared_byte_bus_o))
    else $error("data changed in write");
  AST_RD_PULSE: assert property (
    $fell(read_strobe_low) |-> s_rlow ##1 read_strobe_low)
    else $error("read pulse length");
  AST_RD_FLOAT: assert property (!read_strobe_low |->
    !shared_byte_bus_oe && write_strobe_n && !cmd_latch && !addr_latch)
    else $error("host active in read");
  AST_BUSY_QUIET: assert property (
    !ready_busy_line |-> write_strobe_n && read_strobe_low)
    else $error("strobe while busy");
endmodule // nfh_checker

bind nfh_host nfh_checker chk_u (.clk, .rst_n, .cmd_latch, .addr_latch,
  .write_strobe_n, .read_strobe_low, .shared_byte_bus_o,
  .shared_byte_bus_oe, .ready_busy_line);
`default_nettype wire

// file: test/nfh_flash_model.sv
// Behavioural NAND device on the host pins
`timescale 1ns/1ns
`default_nettype none
module nfh_flash_model #(
  parameter logic [7:0] ID0 = 8'h3c  // Arbitrary id byte
) (
  input  wire logic       cle,   // Cmd latch
  input  wire logic       ale,   // Addr latch
  input  wire logic       ce_n,  // Select
  input  wire logic       we_n,  // Write strobe
  input  wire logic       rd_n,  // Read strobe
  input  wire logic       wp_n,  // Guard
  input  wire logic [7:0] din,   // Bus level
  output var  logic [7:0] dq,    // Output byte
  output var  logic       dq_oe, // Drives bus
  output var  logic       rb,    // Ready line
  output var  int         bad    // Address faults
);
  logic [7:0]  pg[2112];
  logic [7:0]  mem[int];
  logic [7:0]  a[5];
  logic [7:0]  cmd = 0;
  logic [11:0] col = 0;
  int          ac = 0;
  int          r;
  wire  [18:0] row = {a[4][2:0], a[3], a[2]};
  initial rb = 1;  // init done at power-up
  initial dq = 0;
  initial bad = 0;
  // Drive only while selected with read low
  assign dq_oe = !ce_n && !rd_n;
  // Latch on write rise; busy blocks all input
  always @(posedge we_n) if (!ce_n && rb) begin
    if (cle && !ale) begin
      cmd = din;
      if (din inside {8'h00, 8'h05, 8'h85, 8'h90}) ac = 0;
      if (din == 8'h80) ac = 0;
      if (din == 8'h80) pg = '{default: 8'hff};
      if (din == 8'h60) ac = 2;
      if (din == 8'h30) for (int i = 0; i < 2112; i++)
        pg[i] = mem.exists(row * 4096 + i) ? mem[row * 4096 + i] : 8'hff;
      if (din == 8'h10 && wp_n) for (int i = 0; i < 2112; i++)
        mem[row * 4096 + i] = pg[i];
      if (din == 8'hd0 && wp_n) for (int p = 0; p < 128; p++)
        for (int i = 0; i < 2112; i++) mem.delete({row[18:7], 7'(p)} * 4096 + i);
      if (din inside {8'h30, 8'h10, 8'hd0, 8'hff}) begin
        rb = 0;
        #400 rb = 1;
      end
    end else if (ale && !cle) begin
      if ((ac == 1 && din[7:4] != 0) || (ac == 4 && din[7:3] != 0)) bad++;
      a[ac % 5] = din;
      ac++;
      if (ac == 2) col = {a[1][3:0], a[0]};
    end else if (cmd inside {8'h80, 8'h85}) begin
      pg[col] = din;
      col++;
    end
  end
  // Next page byte on each falling read strobe; after 70 or 90 the same byte again
  always @(negedge rd_n) if (!ce_n) begin
    r = col;
    if (!(cmd inside {8'h70, 8'h90})) col++;
    #30 dq = cmd == 8'h70 ? {wp_n, rb, rb, 5'h0} : cmd == 8'h90 ? ID0 : pg[r];
  end
  // Released bus shows the last byte read again, as the bench resolves it to ~d_o
  always @(posedge rd_n) dq = ~dq;
endmodule // nfh_flash_model
`default_nettype wire

// file: test/nfh_host_tb.sv
// Self-checking bench for the NAND host controller
`timescale 1ns/1ns
`default_nettype none
module nfh_host_tb;
  import nfh_pkg::*;
  logic        clk = 0;
  logic        rst_n = 0;
  logic [7:0]  awaddr = 0;
  logic [7:0]  araddr = 0;
  logic        awvalid = 0;
  logic        wvalid = 0;
  logic        bready = 0;
  logic        arvalid = 0;
  logic        rready = 0;
  logic [31:0] wdata = 0;
  logic [31:0] rdata;
  logic [31:0] v;
  logic [31:0] rs;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        cle, ale, ce_n, we_n, rd_n, wp_n, oe, d_oe, rb;
  logic [7:0]  bo, d_o;
  logic [7:0]  pat[3] = '{8'ha5, 8'h5a, 8'h3c};
  int          bad;
  int          fails = 0;
  int          n_checks = 0;
  wire  [7:0]  bus = oe ? bo : d_oe ? d_o : ~d_o;  // Resolved bus
  always #4 clk = ~clk;
  nfh_host dut_u (.clk, .rst_n, .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .cmd_latch(cle), .addr_latch(ale),
    .select_n(ce_n), .write_strobe_n(we_n), .read_strobe_low(rd_n),
    .guard_n(wp_n), .shared_byte_bus_o(bo), .shared_byte_bus_oe(oe),
    .shared_byte_bus_i(bus), .ready_busy_line(rb));
  nfh_flash_model dev_u (.cle, .ale, .ce_n, .we_n, .rd_n, .wp_n, .din(bus),
    .dq(d_o), .dq_oe(d_oe), .rb, .bad);
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Register write, address and data together
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    awaddr  <= ad;
    wdata   <= d;
    awvalid <= 1;
    wvalid  <= 1;
    bready  <= 1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
    rs = 32'(bresp);
  endtask
  // Register read
  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    @(posedge clk);
    araddr  <= ad;
    arvalid <= 1;
    rready  <= 1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rready <= 0;
    d = rdata;
    rs = 32'(rresp);
  endtask
  // Order an operation and poll until idle
  task automatic op(input logic [3:0] o, input logic [7:0] b = 0);
    wr(REG_CTRL, {16'h0, b, 4'h0, o});
    v = 1;
    for (int i = 0; i < 5000 && v[0] !== 1'b0; i++) rd(REG_STATUS, v);
    // Poll limit run out counts as a mismatch
    if (v[0] !== 1'b0) begin
      fails++;
      test_done();
    end
  endtask
  // Fetch one data byte and compare
  task automatic rdb(input string nm, input logic [7:0] e);
    op(OP_RDBYTE);
    rd(REG_STATUS, v);
    chk(nm, v >> 8 & 32'hff, {24'h0, e});
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #600000;
    fails++;
    test_done();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    rd(REG_STATUS, v);
    chk("idle status", v & 32'h7, 32'h2);
    chk("guard at reset", 32'(wp_n), 32'h0);
    rd(8'h20, v);
    chk("unmapped read", rs, {30'h0, RESP_SLVERR});
    wr(8'h24, 1);
    chk("unmapped write", rs, {30'h0, RESP_SLVERR});
    op(OP_PROG);
    chk("guarded refusal", v & 32'h4, 32'h4);
    wr(REG_CFG, 1);
    wr(REG_COL, 0);
    wr(REG_ROW, 32'h481);
    op(OP_PROG);
    foreach (pat[i]) op(OP_WRBYTE, pat[i]);
    wr(REG_COL, 32'h830);
    op(OP_INCOL);
    op(OP_WRBYTE, 8'h77);
    rd(REG_STATUS, v);
    chk("bytes loaded", v >> 16 & 32'hfff, 32'h4);
    op(OP_CONFIRM);
    op(OP_STATUS);
    op(OP_RDBYTE);
    rd(REG_STATUS, v);
    chk("status byte", v & 32'hff38, 32'he030);
    wr(REG_COL, 0);
    op(OP_READ);
    foreach (pat[i]) rdb("page byte", pat[i]);
    wr(REG_COL, 32'h830);
    op(OP_OUTCOL);
    rdb("moved column", 8'h77);
    op(OP_ERASE);
    op(OP_READ);
    rdb("erased byte", 8'hff);
    op(OP_IDENT);
    rdb("id byte", 8'h3c);
    op(OP_RESET);
    rd(REG_STATUS, v);
    chk("ready after reset", v & 32'h3, 32'h2);
    wr(REG_CFG, 32'h3);
    @(posedge clk);
    chk("standby select", 32'(ce_n), 32'h1);
    chk("address format", 32'(bad), 32'h0);
    test_done();
  end
endmodule // nfh_host_tb
`default_nettype wire
